//--- rtl/alu_pkg.sv
// Operation
// - Core control bits 15..4 and 1..0 always read back as zero.
// - Extension bit reads one exactly when priority exceeds seven; masks user interrupts.
// - Bit two opens the program window into data space; resets to zero.
// - The ALU is 16 bits wide: add, subtract, shift and logic.
// - Arithmetic is two's complement unless an operation says otherwise.
// - ALU updates carry, zero, negative, overflow and digit-carry flags per operation.
// - For subtraction carry means no borrow and digit-carry means no digit borrow.
// - Each operation runs in byte or word size as the instruction selects.
// - Operands come from registers or memory; results go back to either.
// - A 17 by 17 multiplier serves unsigned, signed and mixed operands.
// - Multiply modes: SxS, UxU, UxS, S or U by literal, byte UxU.
// - Signed and unsigned divide of 32 or 16 bit dividend by 16 bits.
// - Each divide leaves quotient in register zero and remainder in register one.
// - Divisor from any register; long dividend from an aligned pair, high on top.
// - Divide iterates one cycle per divisor bit, 16 of its 19 cycles, same for long and short.
// - Barrel shifter does arithmetic right, logic right or left up to fifteen.
// - Multi-bit shifts accept register-direct source and destination only.
// - Single-bit shifts work on a source register or in place in memory.
// - Multi-bit shift amount comes from a named register or a literal.
// - Priority level is the extension bit above the three status priority bits.
// - Each divide completes in nineteen cycles and may pause at any cycle boundary.
package alu_pkg;

  // ****************************************
  // Widths and counts
  // ****************************************
  localparam int DATA_WIDTH  = 16;
  localparam int BYTE_WIDTH  = 8;
  localparam int NIBBLE_WIDTH = 4;
  localparam int MUL_WIDTH   = 17;
  localparam int PROD_WIDTH  = 32;
  localparam int SHIFT_WIDTH = 4;
  localparam int LIT_WIDTH   = 5;
  localparam int IPL_WIDTH   = 3;
  localparam int DIV_STEPS   = 16;
  localparam int DIV_CYCLES  = 19;
  localparam int COUNT_WIDTH = 5;

  // ****************************************
  // Status flag positions and core control layout
  // ****************************************
  localparam int FLAG_C  = 0;
  localparam int FLAG_Z  = 1;
  localparam int FLAG_OV = 2;
  localparam int FLAG_N  = 3;
  localparam int FLAG_DC = 8;
  localparam int CC_EXT_BIT    = 3;
  localparam int CC_WINDOW_BIT = 2;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] CC_RESET     = 16'h0000;
  localparam logic [3:0]  USER_LEVEL_MAX = 4'h7;

  // ****************************************
  // Operation codes and states
  // ****************************************
  typedef enum logic [3:0] {
    op_add, op_sub, op_and, op_ior, op_xor,
    op_shl1, op_asr1, op_lsr1, op_shl_n, op_asr_n, op_lsr_n
  } alu_op_type;

  typedef enum logic [2:0] {
    mul_ss, mul_uu, mul_us, mul_s_lit, mul_u_lit, mul_byte_uu
  } mul_mode_type;

  typedef enum logic [4:0] {
    div_idle  = 5'h01,
    div_setup = 5'h02,
    div_iter  = 5'h04,
    div_fix   = 5'h08,
    div_fin   = 5'h10
  } div_state_type;

endpackage

//--- rtl/cpu_alu_mul_div_shift.sv
`timescale 1ns/100ps
module cpu_alu_mul_div_shift
(
  // Clock, reset, enable
  input  wire logic                         mclk,
  input  wire logic                         rst,
  input  wire logic                         clk_en,
  // ALU request
  input  wire logic                         op_valid,
  input  wire alu_pkg::alu_op_type          op_code,
  input  wire logic                         byte_mode,
  input  wire logic [alu_pkg::DATA_WIDTH-1:0] reg_operand_a,
  input  wire logic [alu_pkg::DATA_WIDTH-1:0] mem_operand_a,
  input  wire logic [alu_pkg::DATA_WIDTH-1:0] operand_b,
  input  wire logic                         src_is_memory,
  input  wire logic                         dst_is_memory,
  input  wire logic                         shift_from_register,
  input  wire logic [alu_pkg::DATA_WIDTH-1:0] shift_reg_value,
  input  wire logic [alu_pkg::SHIFT_WIDTH-1:0] shift_literal,
  // ALU answer
  output logic [alu_pkg::DATA_WIDTH-1:0]    result,
  output logic                              result_valid,
  output logic                              result_byte,
  output logic                              result_to_memory,
  output logic                              op_refused,
  // Status flags
  input  wire logic                         status_write,
  input  wire logic [alu_pkg::DATA_WIDTH-1:0] status_wdata,
  output logic [alu_pkg::DATA_WIDTH-1:0]    alu_status_register,
  // Multiplier
  input  wire logic                         mul_valid,
  input  wire alu_pkg::mul_mode_type        mul_mode,
  input  wire logic [alu_pkg::DATA_WIDTH-1:0] mul_a,
  input  wire logic [alu_pkg::DATA_WIDTH-1:0] mul_b,
  input  wire logic [alu_pkg::LIT_WIDTH-1:0] mul_literal,
  output logic [alu_pkg::PROD_WIDTH-1:0]    mul_product,
  output logic                              mul_done,
  // Divider
  input  wire logic                         div_start,
  input  wire logic                         div_signed,
  input  wire logic                         div_long,
  input  wire logic                         div_hold,
  input  wire logic [alu_pkg::DATA_WIDTH-1:0] dividend_low,
  input  wire logic [alu_pkg::DATA_WIDTH-1:0] dividend_high,
  input  wire logic [alu_pkg::DATA_WIDTH-1:0] divisor,
  output logic                              div_busy,
  output logic                              div_done,
  output logic [alu_pkg::DATA_WIDTH-1:0]    working_register_zero,
  output logic [alu_pkg::DATA_WIDTH-1:0]    working_register_one,
  // Core control
  input  wire logic                         cc_write,
  input  wire logic [alu_pkg::DATA_WIDTH-1:0] cc_wdata,
  input  wire logic                         priority_ext_set,
  input  wire logic [alu_pkg::IPL_WIDTH-1:0] status_priority,
  output logic [alu_pkg::DATA_WIDTH-1:0]    core_control,
  output logic [alu_pkg::IPL_WIDTH:0]       cpu_priority_level,
  output logic                              user_irq_mask,
  output logic                              program_window_enable
);
  import alu_pkg::*;

  // ****************************************
  // Core control register
  // ****************************************
  logic priority_level_extension;

  // Set from the exception logic wins over a software clear
  always_ff @(posedge mclk)
  begin
    if (rst)
      priority_level_extension <= CC_RESET[CC_EXT_BIT];
    else if (clk_en)
    begin
      if (priority_ext_set)
        priority_level_extension <= 1'b1;
      else if (cc_write && !cc_wdata[CC_EXT_BIT])
        priority_level_extension <= 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      program_window_enable <= CC_RESET[CC_WINDOW_BIT];
    else if (clk_en && cc_write)
      program_window_enable <= cc_wdata[CC_WINDOW_BIT];
  end

  always_comb
  begin
    core_control = '0;
    core_control[CC_EXT_BIT] = priority_level_extension;
    core_control[CC_WINDOW_BIT] = program_window_enable;
  end

  assign cpu_priority_level = {priority_level_extension, status_priority};
  assign user_irq_mask = cpu_priority_level > USER_LEVEL_MAX;

  // ****************************************
  // ALU and barrel shifter
  // ****************************************
  logic [DATA_WIDTH-1:0]  opa, bv, ext_a, res_w, next_result;
  logic [DATA_WIDTH:0]    sum_w;
  logic [BYTE_WIDTH:0]    sum_b;
  logic [NIBBLE_WIDTH:0]  sum_n;
  logic [SHIFT_WIDTH-1:0] amt;
  logic [DATA_WIDTH-1:0]  new_flags, flag_mask, next_status;
  logic                   carry_arith, carry_shift, is_multi, refuse;

  always_comb
  begin
    opa = src_is_memory ? mem_operand_a : reg_operand_a;
    bv = (op_code == op_sub) ? ~operand_b : operand_b;
    sum_w = {1'b0, opa} + {1'b0, bv} + {{DATA_WIDTH{1'b0}}, op_code == op_sub};
    sum_b = {1'b0, opa[BYTE_WIDTH-1:0]} + {1'b0, bv[BYTE_WIDTH-1:0]}
      + {{BYTE_WIDTH{1'b0}}, op_code == op_sub};
    sum_n = {1'b0, opa[NIBBLE_WIDTH-1:0]} + {1'b0, bv[NIBBLE_WIDTH-1:0]}
      + {{NIBBLE_WIDTH{1'b0}}, op_code == op_sub};
    amt = shift_from_register ? shift_reg_value[SHIFT_WIDTH-1:0]
      : shift_literal;
    // Byte shifts run on the extended low byte, then keep its low byte
    ext_a = opa;
    if (byte_mode)
      ext_a = (op_code == op_asr1 || op_code == op_asr_n)
        ? {{BYTE_WIDTH{opa[BYTE_WIDTH-1]}}, opa[BYTE_WIDTH-1:0]}
        : {{BYTE_WIDTH{1'b0}}, opa[BYTE_WIDTH-1:0]};
    carry_arith = byte_mode ? sum_b[BYTE_WIDTH] : sum_w[DATA_WIDTH];
    carry_shift = (op_code == op_shl1)
      ? (byte_mode ? opa[BYTE_WIDTH-1] : opa[DATA_WIDTH-1]) : opa[0];
    is_multi = op_code inside {op_shl_n, op_asr_n, op_lsr_n};
    refuse = is_multi && (src_is_memory || dst_is_memory);
    unique case (op_code)
      op_add, op_sub: res_w = sum_w[DATA_WIDTH-1:0];
      op_and:   res_w = opa & operand_b;
      op_ior:   res_w = opa | operand_b;
      op_xor:   res_w = opa ^ operand_b;
      op_shl1:  res_w = {ext_a[DATA_WIDTH-2:0], 1'b0};
      op_asr1:  res_w = {ext_a[DATA_WIDTH-1], ext_a[DATA_WIDTH-1:1]};
      op_lsr1:  res_w = {1'b0, ext_a[DATA_WIDTH-1:1]};
      op_shl_n: res_w = ext_a << amt;
      op_asr_n: res_w = DATA_WIDTH'($signed(ext_a) >>> amt);
      op_lsr_n: res_w = ext_a >> amt;
      default:  res_w = opa;
    endcase
    next_result = byte_mode
      ? {opa[DATA_WIDTH-1:BYTE_WIDTH], res_w[BYTE_WIDTH-1:0]} : res_w;
    new_flags = '0;
    new_flags[FLAG_Z] = byte_mode ? (res_w[BYTE_WIDTH-1:0] == '0)
      : (res_w == '0);
    new_flags[FLAG_N] = byte_mode ? res_w[BYTE_WIDTH-1]
      : res_w[DATA_WIDTH-1];
    new_flags[FLAG_C] = (op_code inside {op_add, op_sub})
      ? carry_arith : carry_shift;
    new_flags[FLAG_DC] = byte_mode ? sum_n[NIBBLE_WIDTH]
      : sum_b[BYTE_WIDTH];
    new_flags[FLAG_OV] = byte_mode
      ? (opa[BYTE_WIDTH-1] == bv[BYTE_WIDTH-1])
        && (sum_b[BYTE_WIDTH-1] != opa[BYTE_WIDTH-1])
      : (opa[DATA_WIDTH-1] == bv[DATA_WIDTH-1])
        && (sum_w[DATA_WIDTH-1] != opa[DATA_WIDTH-1]);
    flag_mask = '0;
    flag_mask[FLAG_Z] = 1'b1;
    flag_mask[FLAG_N] = 1'b1;
    flag_mask[FLAG_C] = !is_multi && !(op_code inside {op_and, op_ior, op_xor});
    flag_mask[FLAG_OV] = op_code inside {op_add, op_sub};
    flag_mask[FLAG_DC] = op_code inside {op_add, op_sub};
    next_status = alu_status_register;
    if (status_write)
    begin
      next_status = '0;
      next_status[FLAG_C]  = status_wdata[FLAG_C];
      next_status[FLAG_Z]  = status_wdata[FLAG_Z];
      next_status[FLAG_OV] = status_wdata[FLAG_OV];
      next_status[FLAG_N]  = status_wdata[FLAG_N];
      next_status[FLAG_DC] = status_wdata[FLAG_DC];
    end
    // An ALU update in the same cycle overrides a software write
    if (op_valid && !refuse)
      next_status = (next_status & ~flag_mask) | (new_flags & flag_mask);
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      result           <= '0;
      result_valid     <= 1'b0;
      result_byte      <= 1'b0;
      result_to_memory <= 1'b0;
      op_refused       <= 1'b0;
    end
    else if (clk_en)
    begin
      result_valid <= op_valid && !refuse;
      op_refused   <= op_valid && refuse;
      if (op_valid && !refuse)
      begin
        result           <= next_result;
        result_byte      <= byte_mode;
        result_to_memory <= dst_is_memory;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      alu_status_register <= STATUS_RESET;
    else if (clk_en)
      alu_status_register <= next_status;
  end

  // ****************************************
  // Multiplier
  // ****************************************
  logic signed [MUL_WIDTH-1:0]   mul_x, mul_y;
  logic signed [2*MUL_WIDTH-1:0] mul_full;

  // Seventeenth bit carries the sign or a zero, so one signed array serves all
  always_comb
  begin
    mul_x = {1'b0, mul_a};
    mul_y = {1'b0, mul_b};
    unique case (mul_mode)
      mul_ss:      begin mul_x = {mul_a[DATA_WIDTH-1], mul_a};
                         mul_y = {mul_b[DATA_WIDTH-1], mul_b}; end
      mul_uu:      ;
      mul_us:      mul_y = {mul_b[DATA_WIDTH-1], mul_b};
      mul_s_lit:   begin mul_x = {mul_a[DATA_WIDTH-1], mul_a};
                         mul_y = MUL_WIDTH'(mul_literal); end
      mul_u_lit:   mul_y = MUL_WIDTH'(mul_literal);
      mul_byte_uu: begin mul_x = MUL_WIDTH'(mul_a[BYTE_WIDTH-1:0]);
                         mul_y = MUL_WIDTH'(mul_b[BYTE_WIDTH-1:0]); end
      default:     ;
    endcase
    mul_full = mul_x * mul_y;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      mul_product <= '0;
      mul_done    <= 1'b0;
    end
    else if (clk_en)
    begin
      mul_done <= mul_valid;
      if (mul_valid)
        mul_product <= mul_full[PROD_WIDTH-1:0];
    end
  end

  // ****************************************
  // Divider
  // ****************************************
  div_state_type            div_state;
  logic [COUNT_WIDTH-1:0]   div_count;
  logic [DATA_WIDTH:0]      rem, shifted, trial;
  logic [DATA_WIDTH-1:0]    dq, dsor, dvd_lo, dvd_hi;
  logic [PROD_WIDTH-1:0]    dvd_full, dvd_abs;
  logic                     neg_q, neg_r, d_signed, d_long, div_step;

  assign div_busy = div_state != div_idle;
  assign div_step = clk_en && !div_hold;
  assign dvd_full = d_long ? {dvd_hi, dvd_lo}
    : (d_signed ? PROD_WIDTH'($signed(dvd_lo)) : PROD_WIDTH'(dvd_lo));
  assign dvd_abs = (d_signed && dvd_full[PROD_WIDTH-1]) ? -dvd_full : dvd_full;
  assign shifted = {rem[DATA_WIDTH-1:0], dq[DATA_WIDTH-1]};
  assign trial = shifted - {1'b0, dsor};

  // Pausing freezes the divider in whichever state it is in, so an interrupt can slip in
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      div_state <= div_idle;
      div_count <= '0;
      div_done  <= 1'b0;
      rem <= '0; dq <= '0; dsor <= '0; dvd_lo <= '0; dvd_hi <= '0;
      neg_q <= 1'b0; neg_r <= 1'b0; d_signed <= 1'b0; d_long <= 1'b0;
      working_register_zero <= '0;
      working_register_one  <= '0;
    end
    else if (clk_en && div_hold)
      div_done <= 1'b0; // A pause must not stretch the done pulse
    else if (div_step)
    begin
      div_done <= 1'b0;
      unique case (div_state)
        div_idle:
          if (div_start)
          begin
            dvd_lo <= dividend_low; dvd_hi <= dividend_high;
            dsor <= divisor; d_signed <= div_signed; d_long <= div_long;
            div_state <= div_setup;
          end
        div_setup:
        begin
          rem <= {1'b0, dvd_abs[PROD_WIDTH-1:DATA_WIDTH]};
          dq  <= dvd_abs[DATA_WIDTH-1:0];
          dsor <= (d_signed && dsor[DATA_WIDTH-1]) ? -dsor : dsor;
          neg_q <= d_signed && (dvd_full[PROD_WIDTH-1] ^ dsor[DATA_WIDTH-1]);
          neg_r <= d_signed && dvd_full[PROD_WIDTH-1];
          div_count <= '0;
          div_state <= div_iter;
        end
        div_iter:
        begin
          rem <= trial[DATA_WIDTH] ? shifted : trial;
          dq <= {dq[DATA_WIDTH-2:0], !trial[DATA_WIDTH]};
          div_count <= div_count + 1'b1;
          if (div_count == COUNT_WIDTH'(DIV_STEPS - 1))
            div_state <= div_fix;
        end
        div_fix:
        begin
          working_register_zero <= neg_q ? -dq : dq;
          working_register_one <= neg_r ? -rem[DATA_WIDTH-1:0]
            : rem[DATA_WIDTH-1:0];
          div_state <= div_fin;
        end
        div_fin:
        begin
          div_done  <= 1'b1;
          div_state <= div_idle;
        end
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [COUNT_WIDTH-1:0] div_age;
  always_ff @(posedge mclk)
  begin
    if (rst)
      div_age <= '0;
    else if (div_step && !div_busy && div_start)
      div_age <= '0;
    else if (div_step && div_busy)
      div_age <= div_age + 1'b1;
  end

  default clocking dc_clk @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_div_taken; div_step && !div_busy && div_start; endsequence
  sequence s_div_run; div_busy[*2]; endsequence
  property p_div_len; div_done |-> div_age == COUNT_WIDTH'(DIV_CYCLES); endproperty
  a_div_len: assert property (p_div_len) else $error("divide length");
  property p_done_once; clk_en && div_done |=> !div_done; endproperty
  a_done_once: assert property (p_done_once) else $error("pulse");
  property p_div_busy; s_div_taken |=> s_div_run; endproperty
  a_div_busy: assert property (p_div_busy) else $error("divide idle");
  property p_div_math;
    div_done && !d_signed && !d_long && dsor != '0 |->
      PROD_WIDTH'(working_register_zero) * PROD_WIDTH'(dsor)
      + PROD_WIDTH'(working_register_one) == PROD_WIDTH'(dvd_lo);
  endproperty
  a_div_math: assert property (p_div_math) else $error("divide result");
  property p_cc_zero; core_control[15:4] == '0 && core_control[1:0] == '0;
  endproperty
  a_cc_zero: assert property (p_cc_zero) else $error("reserved bits");
  property p_mask; user_irq_mask == priority_level_extension; endproperty
  a_mask: assert property (p_mask) else $error("user mask");
  property p_window; clk_en && cc_write |=>
    program_window_enable == $past(cc_wdata[CC_WINDOW_BIT]); endproperty
  a_window: assert property (p_window) else $error("window bit");
  property p_sub_c; clk_en && op_valid && op_code == op_sub && !byte_mode
    |=> alu_status_register[FLAG_C] == ($past(opa) >= $past(operand_b));
  endproperty
  a_sub_c: assert property (p_sub_c) else $error("borrow flag");
  property p_refuse; clk_en && op_valid && refuse
    |=> op_refused && !result_valid; endproperty
  a_refuse: assert property (p_refuse) else $error("shift mode");
  property p_asr; clk_en && op_valid && op_code == op_asr_n && !byte_mode
    && !refuse |=> result == DATA_WIDTH'($signed($past(opa)) >>> $past(amt));
  endproperty
  a_asr: assert property (p_asr) else $error("barrel shift");
  property p_mul; clk_en && mul_valid && mul_mode == mul_ss |=> mul_product ==
    PROD_WIDTH'($signed($past(mul_a)) * $signed($past(mul_b)));
  endproperty
  a_mul: assert property (p_mul) else $error("signed product");
endmodule

//--- test/far_side_model.sv
`timescale 1ns/100ps
module far_side_model
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Bench control
  input  wire logic        stall_en,
  // Results from the datapath
  input  wire logic [15:0] result,
  input  wire logic        result_valid,
  input  wire logic        result_to_memory,
  // Pause request and written copies
  output logic             div_hold,
  output logic [15:0]      reg_copy,
  output logic [15:0]      mem_copy
);
  // ****************************************
  // Divide pauses and write-back
  // ****************************************
  // Random pauses stand in for interrupts landing mid-divide
  always_ff @(posedge mclk)
    div_hold <= !rst && stall_en && ($urandom % 3 == 0);
  always_ff @(posedge mclk)
    if (result_valid && result_to_memory)
      mem_copy <= result;
    else if (result_valid)
      reg_copy <= result;
endmodule

//--- test/test_cpu_alu_mul_div_shift.sv
`timescale 1ns/100ps
module test_cpu_alu_mul_div_shift;
  import alu_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic mclk = 0, rst = 1, clk_en = 1, op_valid = 0, byte_mode = 0;
  alu_op_type op_code = op_add;
  mul_mode_type mul_mode = mul_ss;
  logic src_is_memory = 0, dst_is_memory = 0, shift_from_register = 0;
  logic [15:0] reg_operand_a = 0, mem_operand_a = 0, operand_b = 0;
  logic [15:0] shift_reg_value = 0, status_wdata = 0, cc_wdata = 0;
  logic [15:0] mul_a = 0, mul_b = 0, dividend_low = 0, dividend_high = 0;
  logic [15:0] divisor = 1;
  logic [3:0]  shift_literal = 0;
  logic [4:0]  mul_literal = 0;
  logic [2:0]  status_priority = 0;
  logic status_write = 0, mul_valid = 0, div_start = 0, div_signed = 0;
  logic div_long = 0, cc_write = 0, priority_ext_set = 0, stall_en = 0;
  logic        div_hold;
  logic [15:0] result, alu_status_register, working_register_zero;
  logic [15:0] working_register_one, core_control, reg_copy, mem_copy;
  logic [31:0] mul_product, e;
  logic [3:0]  cpu_priority_level, st;
  logic result_valid, result_byte, result_to_memory, op_refused, mul_done;
  logic div_busy, div_done, user_irq_mask, program_window_enable;
  logic [31:0] q_alu[$], q_mul[$], q_div[$];
  int n_fail = 0, tests_run = 0, cnt = 0;

  cpu_alu_mul_div_shift dut (.*);
  far_side_model partner (.mclk(mclk), .rst(rst), .stall_en(stall_en),
    .result(result), .result_valid(result_valid),
    .result_to_memory(result_to_memory), .div_hold(div_hold),
    .reg_copy(reg_copy), .mem_copy(mem_copy));

  always #20 mclk = ~mclk;

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(string nm, logic [37:0] x, logic [37:0] s);
    tests_run++;
    if (x !== s)
    begin
      $display("wrong value %s expected %h seen %h", nm, x, s);
      n_fail++;
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Word model; flags {N,OV,Z,C} kept in st, untouched ones stay
  function automatic logic [15:0] model(alu_op_type o, logic [15:0] a,
                                        logic [15:0] b, logic [3:0] n);
    logic [16:0] w;
    case (o)
      op_add:   w = {1'b0, a} + {1'b0, b};
      op_sub:   w = {1'b0, a} - {1'b0, b};
      op_and:   w = {1'b0, a & b};
      op_ior:   w = {1'b0, a | b};
      op_xor:   w = {1'b0, a ^ b};
      op_shl1:  w = {a, 1'b0};
      op_asr1:  w = {a[0], a[15], a[15:1]};
      op_lsr1:  w = {a[0], 1'b0, a[15:1]};
      op_shl_n: w = {1'b0, a << n};
      op_asr_n: w = {1'b0, 16'($signed(a) >>> n)};
      default:  w = {1'b0, a >> n};
    endcase
    if (o inside {op_add, op_sub, op_shl1, op_asr1, op_lsr1})
      st[0] = (o == op_sub) ? !w[16] : w[16];
    if (o inside {op_add, op_sub})
      st[2] = (a[15] == (b[15] ^ (o == op_sub))) && (w[15] != a[15]);
    st[1] = (w[15:0] == 16'h0000);
    st[3] = w[15];
    return w[15:0];
  endfunction

  task automatic alu_op(alu_op_type o, logic bm, logic sm, logic dm);
    logic [15:0] a, b, r, t;
    logic [3:0] n;
    logic rf;
    a = 16'($urandom);
    b = 16'($urandom);
    n = 4'($urandom);
    rf = (o >= op_shl_n) && (sm || dm);
    @(posedge mclk);
    op_valid <= 1;
    op_code <= o;
    byte_mode <= bm;
    src_is_memory <= sm;
    dst_is_memory <= dm;
    reg_operand_a <= sm ? ~a : a;
    mem_operand_a <= sm ? a : ~a;
    operand_b <= b;
    shift_from_register <= b[0];
    shift_reg_value <= {b[15:4], b[0] ? n : ~n};
    shift_literal <= b[0] ? ~n : n;
    // Byte ops run high-aligned so carries leave bit 15
    if (rf)
      r = 16'h0000;
    else if (bm)
    begin
      t = model(o, {a[7:0], 8'h00}, {b[7:0], 8'h00}, n);
      r = {a[15:8], t[15:8]};
    end
    else
      r = model(o, a, b, n);
    q_alu.push_back({9'h0, rf ? 2'b00 : {dm, bm}, rf, st, r});
  endtask

  task automatic mul_op(mul_mode_type m);
    logic [15:0] a, b;
    logic [4:0] l;
    logic signed [33:0] p;
    a = 16'($urandom);
    b = 16'($urandom);
    l = 5'($urandom);
    case (m)
      mul_ss:    p = $signed(a) * $signed(b);
      mul_uu:    p = a * b;
      mul_us:    p = $signed({1'b0, a}) * $signed(b);
      mul_s_lit: p = $signed(a) * $signed({1'b0, l});
      mul_u_lit: p = a * l;
      default:   p = a[7:0] * b[7:0];
    endcase
    @(posedge mclk);
    mul_valid <= 1;
    mul_mode <= m;
    mul_a <= a;
    mul_b <= b;
    mul_literal <= l;
    q_mul.push_back(p[31:0]);
  endtask

  task automatic div_op(logic sg, logic lg);
    logic [15:0] lo, hi, d, q, r;
    int k;
    lo = 16'($urandom);
    hi = 16'($urandom);
    d = 16'(($urandom % 30000) + 2);
    if (sg)
    begin
      d = hi[0] ? -d : d;
      hi = lg ? {16{lo[15]}} : hi;
      q = $signed(lo) / $signed(d);
      r = $signed(lo) % $signed(d);
    end
    else
    begin
      hi = lg ? hi % d : hi;
      q = lg ? {hi, lo} / d : lo / d;
      r = lg ? {hi, lo} % d : lo % d;
    end
    q_div.push_back({r, q});
    @(posedge mclk);
    div_start <= 1;
    div_signed <= sg;
    div_long <= lg;
    dividend_low <= lo;
    dividend_high <= hi;
    divisor <= d;
    for (k = 0; k < 60; k++)
    begin
      @(posedge mclk);
      if (!div_hold && !div_busy)
        break;
    end
    div_start <= 0;
    for (k = 0; k < 200 && div_done !== 1'b1; k++)
      @(posedge mclk);
    if (k >= 60 * 4 - 40)
    begin
      n_fail++;
      complete_run();
    end
  endtask

  // ****************************************
  // Result watcher
  // ****************************************
  always @(posedge mclk)
  begin
    if (result_valid === 1'b1 || op_refused === 1'b1)
    begin
      e = q_alu.size() ? q_alu.pop_front() : 32'hx;
      check("alu", e, {op_refused ? 2'b00 : {result_to_memory, result_byte},
        op_refused, alu_status_register[3:0],
        op_refused ? 16'h0000 : result});
    end
    if (mul_done === 1'b1)
    begin
      e = q_mul.size() ? q_mul.pop_front() : 32'hx;
      check("product", e, mul_product);
    end
    if (div_done === 1'b1)
    begin
      e = q_div.size() ? q_div.pop_front() : 32'hx;
      check("quotient", e, {working_register_one,
                            working_register_zero});
      check("div_cycles", 19, cnt);
    end
    if (div_start && !div_hold && !div_busy)
      cnt = 0;
    else if (!div_hold)
      cnt++;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    void'($urandom(29));
    repeat (3) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    status_write <= 1;
    status_wdata <= 16'hffff;
    cc_write <= 1;
    cc_wdata <= 16'hffff;
    #1 check("reset", 0, {alu_status_register, core_control});
    @(posedge mclk);
    status_write <= 0;
    cc_write <= 0;
    priority_ext_set <= 1;
    status_priority <= 3'h5;
    #1 check("status", 16'h010f, alu_status_register);
    check("ctrl", 22'h00115, {core_control, cpu_priority_level,
      user_irq_mask, program_window_enable});
    st = 4'hf;
    @(posedge mclk);
    priority_ext_set <= 0;
    cc_write <= 1;
    cc_wdata <= 16'h0000;
    #1 check("ctrl", 22'h00337, {core_control, cpu_priority_level,
      user_irq_mask, program_window_enable});
    @(posedge mclk);
    cc_write <= 0;
    #1 check("ctrl", 22'h0014, {core_control, cpu_priority_level,
      user_irq_mask, program_window_enable});
    for (int i = 0; i <= 10; i++)
      alu_op(alu_op_type'(i), 0, 0, 0);
    for (int i = 0; i < 60; i++)
      alu_op(alu_op_type'($urandom % 11), 0, 1'($urandom),
             1'($urandom));
    for (int i = 0; i < 20; i++)
      alu_op(alu_op_type'($urandom % 5), 1, 0, 1'($urandom));
    @(posedge mclk);
    op_valid <= 0;
    for (int i = 0; i < 12; i++)
      mul_op(mul_mode_type'(i % 6));
    @(posedge mclk);
    mul_valid <= 0;
    stall_en <= 1;
    for (int i = 0; i < 8; i++)
      div_op(i[0], i[1]);
    repeat (3) @(posedge mclk);
    check("pending", 0, q_alu.size() + q_mul.size() + q_div.size());
    complete_run();
  end
endmodule
